// ---- rtl/acc_regs.vh ----
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACC_IDX_CONFIG 8'h13
`define ACC_IDX_OFFSET_UPPER 8'h14
`define ACC_IDX_OFFSET_LOWER 8'h15
`define ACC_IDX_GAIN_UPPER 8'h16
`define ACC_IDX_GAIN_LOWER 8'h17

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_RST_CONFIG 16'h0000
`define ACC_RST_OFFSET_UPPER 16'h0000
`define ACC_RST_OFFSET_LOWER 16'h0000
`define ACC_RST_GAIN_UPPER 16'h8000
`define ACC_RST_GAIN_LOWER 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACC_PHASE_MSB 15
`define ACC_PHASE_LSB 6
`define ACC_DCOFF_BIT 2
`define ACC_SEL_MSB 1
`define ACC_SEL_LSB 0
`define ACC_LOWBITS_MSB 15
`define ACC_LOWBITS_LSB 8

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define ACC_MASK_CONFIG 16'hffc7
`define ACC_MASK_FULL 16'hffff
`define ACC_MASK_LOW 16'hff00

// ----------------------------------------------------------------
// Input select encodings
// ----------------------------------------------------------------
`define ACC_SEL_NORMAL 2'h0
`define ACC_SEL_SHORTED 2'h1
`define ACC_SEL_TEST_POS 2'h2
`define ACC_SEL_TEST_NEG 2'h3

`endif

// ---- rtl/acc_ch2_regs.v ----
`timescale 1ns/1ns
// How it works
// - Config bits 15:6 hold signed ten-bit phase delay in modulator cycles.
// - Reserved config bits 5:3 and low-register bits 7:0 read zero.
// - Config bit 2 high turns channel DC filter off, else global setting.
// - Config bits 1:0 pick normal, shorted, positive or negative test input.
// - Offset upper register holds offset bits 23:8 over all sixteen bits.
// - Offset lower register bits 15:8 hold offset bits 7:0.
// - Assembled 24-bit offset is signed two's complement.
// - Assembled 24-bit gain is unsigned, range zero to just under two.
// - Gain upper register at 16h holds gain 23:8, resets to 8000h.
// - Gain lower register at 17h bits 15:8 hold gain bits 7:0.
// - Config 13h, offsets 14h and 15h; all but gain upper reset 0000h.
`include "acc_regs.vh"

module acc_ch2_regs (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg signed [9:0] ch2_phase_delay,
    output reg ch2_dc_filter_off,
    output reg [1:0] ch2_input_select,
    output reg signed [23:0] ch2_offset,
    output reg [23:0] ch2_gain
);

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------
reg [15:0] ch2_config;
reg [15:0] ch2_offset_upper;
reg [15:0] ch2_offset_lower;
reg [15:0] ch2_gain_upper;
reg [15:0] ch2_gain_lower;

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
wire [9:0] idx;
wire aligned;
wire hit_cfg;
wire hit_ou;
wire hit_ol;
wire hit_gu;
wire hit_gl;
wire mapped;
wire access;
wire do_write;
wire [1:0] lane_we;
wire [15:0] wdata;

assign idx = paddr[11:2];
assign aligned = (paddr[1:0] == 2'h0);
assign hit_cfg = aligned && (idx == {2'h0, `ACC_IDX_CONFIG});
assign hit_ou = aligned && (idx == {2'h0, `ACC_IDX_OFFSET_UPPER});
assign hit_ol = aligned && (idx == {2'h0, `ACC_IDX_OFFSET_LOWER});
assign hit_gu = aligned && (idx == {2'h0, `ACC_IDX_GAIN_UPPER});
assign hit_gl = aligned && (idx == {2'h0, `ACC_IDX_GAIN_LOWER});
assign mapped = hit_cfg | hit_ou | hit_ol | hit_gu | hit_gl;
// Access phase, answered by registered pready in the second access cycle (one wait state)
assign access = psel && penable && !pready;
assign do_write = access && pwrite && mapped;
assign wdata = pwdata[15:0];

// ----------------------------------------------------------------
// Byte lane write enables
// ----------------------------------------------------------------
genvar lane;

generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
        assign lane_we[lane] = do_write && pstrb[lane];
    end
endgenerate

// ----------------------------------------------------------------
// Configuration register
// ----------------------------------------------------------------
reg [15:0] next_ch2_config;

always @* begin
    next_ch2_config = ch2_config;
    if (hit_cfg && lane_we[1]) begin
        next_ch2_config[15:8] = wdata[15:8];
    end
    if (hit_cfg && lane_we[0]) begin
        next_ch2_config[7:0] = wdata[7:0];
    end
    next_ch2_config = next_ch2_config & `ACC_MASK_CONFIG;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_config <= `ACC_RST_CONFIG;
    end else begin
        ch2_config <= next_ch2_config;
    end
end

// ----------------------------------------------------------------
// Offset upper register
// ----------------------------------------------------------------
reg [15:0] next_ch2_offset_upper;

always @* begin
    next_ch2_offset_upper = ch2_offset_upper;
    if (hit_ou && lane_we[1]) begin
        next_ch2_offset_upper[15:8] = wdata[15:8];
    end
    if (hit_ou && lane_we[0]) begin
        next_ch2_offset_upper[7:0] = wdata[7:0];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_offset_upper <= `ACC_RST_OFFSET_UPPER;
    end else begin
        ch2_offset_upper <= next_ch2_offset_upper;
    end
end

// ----------------------------------------------------------------
// Offset lower register
// ----------------------------------------------------------------
reg [15:0] next_ch2_offset_lower;

always @* begin
    next_ch2_offset_lower = ch2_offset_lower;
    if (hit_ol && lane_we[1]) begin
        next_ch2_offset_lower[15:8] = wdata[15:8];
    end
    next_ch2_offset_lower = next_ch2_offset_lower & `ACC_MASK_LOW;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_offset_lower <= `ACC_RST_OFFSET_LOWER;
    end else begin
        ch2_offset_lower <= next_ch2_offset_lower;
    end
end

// ----------------------------------------------------------------
// Gain upper register
// ----------------------------------------------------------------
reg [15:0] next_ch2_gain_upper;

always @* begin
    next_ch2_gain_upper = ch2_gain_upper;
    if (hit_gu && lane_we[1]) begin
        next_ch2_gain_upper[15:8] = wdata[15:8];
    end
    if (hit_gu && lane_we[0]) begin
        next_ch2_gain_upper[7:0] = wdata[7:0];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_gain_upper <= `ACC_RST_GAIN_UPPER;
    end else begin
        ch2_gain_upper <= next_ch2_gain_upper;
    end
end

// ----------------------------------------------------------------
// Gain lower register
// ----------------------------------------------------------------
reg [15:0] next_ch2_gain_lower;

always @* begin
    next_ch2_gain_lower = ch2_gain_lower;
    if (hit_gl && lane_we[1]) begin
        next_ch2_gain_lower[15:8] = wdata[15:8];
    end
    next_ch2_gain_lower = next_ch2_gain_lower & `ACC_MASK_LOW;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_gain_lower <= `ACC_RST_GAIN_LOWER;
    end else begin
        ch2_gain_lower <= next_ch2_gain_lower;
    end
end

// ----------------------------------------------------------------
// Read views
// ----------------------------------------------------------------
wire [15:0] view_cfg;
wire [15:0] view_ou;
wire [15:0] view_ol;
wire [15:0] view_gu;
wire [15:0] view_gl;

assign view_cfg = ch2_config & `ACC_MASK_CONFIG;
assign view_ou = ch2_offset_upper;
assign view_ol = ch2_offset_lower & `ACC_MASK_LOW;
assign view_gu = ch2_gain_upper;
assign view_gl = ch2_gain_lower & `ACC_MASK_LOW;

// ----------------------------------------------------------------
// Read data select
// ----------------------------------------------------------------
reg [15:0] next_rdata;

always @* begin
    next_rdata = 16'h0000;
    if (hit_cfg) begin
        next_rdata = view_cfg;
    end else if (hit_ou) begin
        next_rdata = view_ou;
    end else if (hit_ol) begin
        next_rdata = view_ol;
    end else if (hit_gu) begin
        next_rdata = view_gu;
    end else if (hit_gl) begin
        next_rdata = view_gl;
    end
end

// ----------------------------------------------------------------
// Bus answer select
// ----------------------------------------------------------------
reg next_pready;
reg next_pslverr;
reg [31:0] next_prdata;

always @* begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    if (access) begin
        next_pready = 1'b1;
        next_pslverr = !mapped;
        if (!pwrite && mapped) begin
            next_prdata = {16'h0000, next_rdata};
        end
    end
end

// ----------------------------------------------------------------
// Bus answer registers
// ----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        pready <= 1'b0;
    end else begin
        pready <= next_pready;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pslverr <= 1'b0;
    end else begin
        pslverr <= next_pslverr;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        prdata <= 32'h00000000;
    end else begin
        prdata <= next_prdata;
    end
end

// ----------------------------------------------------------------
// Assembled calibration words
// ----------------------------------------------------------------
wire [23:0] offset_word;
wire [23:0] gain_word;

assign offset_word = {ch2_offset_upper,
    ch2_offset_lower[`ACC_LOWBITS_MSB:`ACC_LOWBITS_LSB]};
assign gain_word = {ch2_gain_upper,
    ch2_gain_lower[`ACC_LOWBITS_MSB:`ACC_LOWBITS_LSB]};

// ----------------------------------------------------------------
// Phase delay output
// ----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_phase_delay <= 10'h000;
    end else begin
        ch2_phase_delay <= ch2_config[`ACC_PHASE_MSB:`ACC_PHASE_LSB];
    end
end

// ----------------------------------------------------------------
// Filter disable output
// ----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_dc_filter_off <= 1'b0;
    end else begin
        ch2_dc_filter_off <= ch2_config[`ACC_DCOFF_BIT];
    end
end

// ----------------------------------------------------------------
// Input select output
// ----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_input_select <= `ACC_SEL_NORMAL;
    end else begin
        ch2_input_select <= ch2_config[`ACC_SEL_MSB:`ACC_SEL_LSB];
    end
end

// ----------------------------------------------------------------
// Offset output
// ----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_offset <= 24'h000000;
    end else begin
        ch2_offset <= offset_word;
    end
end

// ----------------------------------------------------------------
// Gain output
// ----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ch2_gain <= 24'h800000;
    end else begin
        ch2_gain <= gain_word;
    end
end

endmodule

// ---- tb/acc_ch2_sva.sv ----
`timescale 1ns/1ns
module acc_ch2_sva (
    input clk,
    input rst,
    input psel,
    input penable,
    input pwrite,
    input [11:0] paddr,
    input [31:0] pwdata,
    input [3:0] pstrb,
    input [31:0] prdata,
    input pready,
    input pslverr,
    input signed [9:0] ch2_phase_delay,
    input ch2_dc_filter_off,
    input [1:0] ch2_input_select,
    input signed [23:0] ch2_offset,
    input [23:0] ch2_gain
);
    wire [7:0] idx = paddr[9:2];
    wire tk = psel & penable & ~pready;
    wire ok = paddr[11:10] == 0 && paddr[1:0] == 0 && idx >= 8'h13 && idx <= 8'h17;
    wire lo = idx == 8'h15 || idx == 8'h17;
    wire wr = pready & pwrite & ok & (&pstrb[1:0]);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_map; tk |=> pready && pslverr == !ok; endproperty
    property p_rsv; pready && !pwrite && ok |-> prdata[31:16] == 0
        && (idx != 8'h13 || prdata[5:3] == 0) && (!lo || prdata[7:0] == 0); endproperty
    property p_ph; wr && idx == 8'h13 |=> ch2_phase_delay == $past(pwdata[15:6]); endproperty
    property p_cf; wr && idx == 8'h13 |=> ch2_dc_filter_off == $past(pwdata[2])
        && ch2_input_select == $past(pwdata[1:0]); endproperty
    property p_ou; wr && idx == 8'h14 |=> ch2_offset[23:8] == $past(pwdata[15:0]); endproperty
    property p_ol; wr && idx == 8'h15 |=> ch2_offset[7:0] == $past(pwdata[15:8]); endproperty
    property p_gl; wr && idx == 8'h17 |=> ch2_gain[7:0] == $past(pwdata[15:8]); endproperty
    property p_rs; $fell(rst) |-> ch2_gain == 24'h800000 && ch2_offset == 0; endproperty
    property p_gu; wr && idx == 8'h16 |=> ch2_gain[23:8] == $past(pwdata[15:0]); endproperty
    property p_ln; pready && pwrite && ok && idx == 8'h14 |=> ch2_offset[15:8] ==
        ($past(pstrb[0]) ? $past(pwdata[7:0]) : $past(ch2_offset[15:8])); endproperty
    a_map: assert property (p_map) else $error("answer");
    a_rsv: assert property (p_rsv) else $error("reserved");
    a_ph: assert property (p_ph) else $error("phase");
    a_cf: assert property (p_cf) else $error("config");
    a_ou: assert property (p_ou) else $error("offset hi");
    a_ol: assert property (p_ol) else $error("offset lo");
    a_gl: assert property (p_gl) else $error("gain lo");
    a_rs: assert property (p_rs) else $error("reset");
    a_gu: assert property (p_gu) else $error("gain hi");
    a_ln: assert property (p_ln) else $error("byte lane");
    cover property (wr && idx == 8'h13);
    cover property (pready && pslverr);
    cover property (pready && !pwrite && lo);
endmodule
bind acc_ch2_regs acc_ch2_sva u_sva (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ch2_phase_delay, .ch2_dc_filter_off,
    .ch2_input_select, .ch2_offset, .ch2_gain);

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 0, stb = 4'hf;
    logic pready, pslverr, er, ch2_dc_filter_off;
    logic signed [9:0] ch2_phase_delay;
    logic [1:0] ch2_input_select;
    logic signed [23:0] ch2_offset;
    logic [23:0] ch2_gain;
    int bad_count = 0, checks = 0;
    logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    logic [15:0] wm [5] = '{16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};
    always #2 clk = ~clk;
    acc_ch2_regs u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .ch2_phase_delay, .ch2_dc_filter_off,
        .ch2_input_select, .ch2_offset, .ch2_gain);
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= stb;
        @(posedge clk) penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            xfer(0, 12'h04c + {i[9:0], 2'h0}, 0);
            chk(rd, {16'h0, rv[i]});
        end
        chk(ch2_gain, 24'h800000);
        for (int i = 0; i < 5; i++) begin
            xfer(1, 12'h04c + {i[9:0], 2'h0}, 32'hffffffff);
            xfer(0, 12'h04c + {i[9:0], 2'h0}, 0);
            chk(rd, {16'h0, wm[i]});
        end
        chk(ch2_offset[23:0], 24'hffffff);
        chk(ch2_gain, 24'hffffff);
        chk(ch2_dc_filter_off, 1);
        for (int i = 0; i < 4; i++) begin
            xfer(1, 12'h04c, {16'h0, 10'h200, 4'h0, i[1:0]});
            chk(ch2_phase_delay[9:0], 10'h200);
            chk({ch2_dc_filter_off, ch2_input_select}, i[1:0]);
        end
        stb = 4'h1;
        xfer(1, 12'h050, 32'h0000a5a5);
        stb = 4'h2;
        xfer(1, 12'h058, 32'h00001234);
        stb = 4'hf;
        xfer(0, 12'h050, 0);
        chk(rd, 32'h0000ffa5);
        xfer(0, 12'h058, 0);
        chk(rd, 32'h000012ff);
        chk(ch2_offset[23:0], 24'hffa5ff);
        chk(ch2_gain, 24'h12ffff);
        xfer(1, 12'h060, 32'hffff);
        chk(er, 1);
        xfer(0, 12'h04e, 0);
        chk(er, 1);
        chk(rd, 0);
        close_out;
    end
    initial begin
        #20000;
        bad_count++;
        close_out;
    end
endmodule
